// File: pkg/lcs_pkg.sv
// constants, register map and state type of the limit compare block
package lcs_pkg;

	// widths and channel counts
	localparam int DATA_W = 8;
	localparam int NUM_VOLT = 5;
	localparam int NUM_TEMP = 3;
	localparam int NUM_CHAN = 8;
	localparam int NUM_FAN = 4;
	localparam int NUM_PWM = 3;
	localparam int NUM_DIODE = 2;
	localparam int TACH_W = 16;
	localparam int VID_W = 5;
	localparam int NUM_LIMITS = 24;
	localparam int LIMIT_IDX_W = 5;

	// bus decode: word index sits in haddr[9:2]
	localparam int WORD_SHIFT = 2;
	localparam int IDX_W = 8;
	localparam int IDX_MSB = WORD_SHIFT + IDX_W - 1;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	localparam logic [1:0] HRESP_OKAY = 2'h0;

	// register indices; byte address is four times the index
	localparam logic [7:0] FAULT_STATUS_TWO_IDX = 8'h42;
	localparam logic [7:0] CORE_VOLTAGE_CODE_IDX = 8'h43;
	localparam logic [7:0] RAIL_2V5_LOW_LIMIT_IDX = 8'h44;
	localparam logic [7:0] RAIL_2V5_HIGH_LIMIT_IDX = 8'h45;
	localparam logic [7:0] CORE_RAIL_LOW_LIMIT_IDX = 8'h46;
	localparam logic [7:0] CORE_RAIL_HIGH_LIMIT_IDX = 8'h47;
	localparam logic [7:0] OWN_SUPPLY_LOW_LIMIT_IDX = 8'h48;
	localparam logic [7:0] OWN_SUPPLY_HIGH_LIMIT_IDX = 8'h49;
	localparam logic [7:0] RAIL_5V_LOW_LIMIT_IDX = 8'h4a;
	localparam logic [7:0] RAIL_5V_HIGH_LIMIT_IDX = 8'h4b;
	localparam logic [7:0] RAIL_12V_LOW_LIMIT_IDX = 8'h4c;
	localparam logic [7:0] RAIL_12V_HIGH_LIMIT_IDX = 8'h4d;
	localparam logic [7:0] REMOTE_ONE_TEMP_LOW_LIMIT_IDX = 8'h4e;
	localparam logic [7:0] REMOTE_ONE_TEMP_HIGH_LIMIT_IDX = 8'h4f;
	localparam logic [7:0] LOCAL_TEMP_LOW_LIMIT_IDX = 8'h50;
	localparam logic [7:0] LOCAL_TEMP_HIGH_LIMIT_IDX = 8'h51;
	localparam logic [7:0] REMOTE_TWO_TEMP_LOW_LIMIT_IDX = 8'h52;
	localparam logic [7:0] REMOTE_TWO_TEMP_HIGH_LIMIT_IDX = 8'h53;
	localparam logic [7:0] FAN_ONE_MIN_COUNT_LOW_IDX = 8'h54;
	localparam logic [7:0] FAN_ONE_MIN_COUNT_HIGH_IDX = 8'h55;
	localparam logic [7:0] FAN_TWO_MIN_COUNT_LOW_IDX = 8'h56;
	localparam logic [7:0] FAN_TWO_MIN_COUNT_HIGH_IDX = 8'h57;
	localparam logic [7:0] FAN_THREE_MIN_COUNT_LOW_IDX = 8'h58;
	localparam logic [7:0] FAN_THREE_MIN_COUNT_HIGH_IDX = 8'h59;
	localparam logic [7:0] FAN_FOUR_MIN_COUNT_LOW_IDX = 8'h5a;
	localparam logic [7:0] FAN_FOUR_MIN_COUNT_HIGH_IDX = 8'h5b;

	// position of each group inside the limit array
	localparam int TEMP_BASE = 10;
	localparam int TACH_BASE = 16;

	// reset values
	localparam logic [7:0] STATUS_RESET = 8'h00;
	localparam logic [7:0] VOLT_LOW_RESET = 8'h00;
	localparam logic [7:0] VOLT_HIGH_RESET = 8'hff;
	localparam logic [7:0] TEMP_LOW_RESET = 8'h81;
	localparam logic [7:0] TEMP_HIGH_RESET = 8'h7f;
	localparam logic [7:0] TACH_MIN_RESET = 8'hff;

	// status bit layout
	localparam int ST_RAIL_12V = 0;
	localparam int ST_OVERHEAT = 1;
	localparam int ST_COOLER_FIRST = 2;
	localparam int ST_DIODE_FIRST = 6;
	localparam int RAIL_12V_CHAN = 4;

	// fan four shares the third pwm output
	localparam int COOLER_FOUR_PWM = 2;
	localparam logic [15:0] FAN_MIN_ALL_ONES = 16'hffff;
	localparam logic [15:0] FAN_MIN_ALL_ZERO = 16'h0000;

	// overheat release hysteresis in degrees (one lsb per degree)
	localparam logic signed [8:0] OVERHEAT_HYST = 9'sh004;

	// power-on value of limit array entry k
	function automatic logic [7:0] lcs_limit_reset(input int k);
		logic [7:0] v;
		if (k >= TACH_BASE) begin
			v = TACH_MIN_RESET;
		end else if (k >= TEMP_BASE) begin
			v = (k % 2 == 1) ? TEMP_HIGH_RESET : TEMP_LOW_RESET;
		end else begin
			v = (k % 2 == 1) ? VOLT_HIGH_RESET : VOLT_LOW_RESET;
		end
		return v;
	endfunction

	// all state of the top module
	typedef struct packed {
		logic [NUM_LIMITS-1:0][7:0] limit;
		logic [7:0] status;
		logic wr_pend;
		logic [IDX_W-1:0] wr_idx;
		logic [31:0] rdata;
	} lcs_state_s;

endpackage

// File: pkg/lcs_cmp_if.sv
// signals between the register bank and the limit comparators
`timescale 1ns/1ps
`default_nettype none
interface lcs_cmp_if;
	import lcs_pkg::*;
	logic [NUM_CHAN-1:0][7:0] meas;
	logic [NUM_CHAN-1:0][7:0] lim_low;
	logic [NUM_CHAN-1:0][7:0] lim_high;
	logic [NUM_FAN-1:0][TACH_W-1:0] tach;
	logic [NUM_FAN-1:0][TACH_W-1:0] fan_min;
	logic [NUM_FAN-1:0] fan_run;
	logic [NUM_CHAN-1:0] chan_fault;
	logic [NUM_FAN-1:0] fan_fault;
	modport cmp (input meas, lim_low, lim_high, tach, fan_min, fan_run,
		output chan_fault, fan_fault);
	modport bank (output meas, lim_low, lim_high, tach, fan_min, fan_run,
		input chan_fault, fan_fault);
endinterface
`default_nettype wire

// File: hdl/lcs_compare.sv
// per-channel limit comparators for rails, temperatures and fans
`timescale 1ns/1ps
`default_nettype none
module lcs_compare (
	lcs_cmp_if.cmp cmp
);
	import lcs_pkg::*;

	// rails are unsigned, temperatures two's complement
	for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
		logic above;
		logic at_or_below;
		if (c < NUM_VOLT) begin : g_volt
			assign above = cmp.meas[c] > cmp.lim_high[c];
			assign at_or_below = cmp.meas[c] <= cmp.lim_low[c];
		end else begin : g_temp
			// one degree past the high limit, or reaching the low limit, trips the channel
			assign above = $signed(cmp.meas[c]) >
				$signed(cmp.lim_high[c]);
			assign at_or_below = $signed(cmp.meas[c]) <=
				$signed(cmp.lim_low[c]);
		end
		assign cmp.chan_fault[c] = above | at_or_below;
	end

	// a larger count means a slower fan
	for (genvar f = 0; f < NUM_FAN; f++) begin : g_fan
		logic armed;
		assign armed = (cmp.fan_min[f] != FAN_MIN_ALL_ONES) &&
			(cmp.fan_min[f] != FAN_MIN_ALL_ZERO);
		assign cmp.fan_fault[f] = cmp.fan_run[f] & armed &
			(cmp.tach[f] > cmp.fan_min[f]);
	end

endmodule
`default_nettype wire

// File: hdl/lcs_top.sv
// limit registers, second fault status and id mirror on an ahb-lite slave
//
// How it works
// - 12V fault sets bit0; read clears if gone
// - overheat sets bit1; clears below threshold-4
// - fan faults set bits 2 to 5
// - fan faults masked while their pwm is off
// - diode open/short sets bits 6 and 7
// - status two at 0x42, read-only, resets zero
// - 0x43 mirrors five id pins, upper bits zero
// - ten voltage limits at 0x44, reset 00/ff
// - limits stay writable regardless of lock
// - high fault only when strictly above limit
// - low fault when equal or below limit
// - six temperature limits at 0x4e, reset 81/7f
// - one degree above high or at low limit trips the channel
// - eight fan minimum bytes at 0x54, reset ff
// - count above minimum means slow or stalled
// - summary flag is or of status two
// - all-ones or all-zero minimum disables fan fault
`timescale 1ns/1ps
`default_nettype none
module lcs_top (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_clk_en,
	// ahb-lite slave
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic o_hreadyout,
	output logic [1:0] o_hresp,
	output logic [31:0] o_hrdata,
	// measured values from the converter and tach logic
	input wire logic [lcs_pkg::NUM_VOLT-1:0][7:0] i_rail_level,
	input wire logic [lcs_pkg::NUM_TEMP-1:0][7:0] i_temp_level,
	input wire logic [lcs_pkg::NUM_FAN-1:0][15:0] i_tach_count,
	input wire logic [lcs_pkg::NUM_PWM-1:0] i_pwm_on,
	input wire logic [7:0] i_critical_temp_threshold,
	input wire logic [lcs_pkg::NUM_DIODE-1:0] i_diode_fault,
	input wire logic [lcs_pkg::VID_W-1:0] i_core_voltage_code_bits,
	// levels toward status register one and the interrupt pin
	output logic [lcs_pkg::NUM_CHAN-1:0] o_limit_fault,
	output logic o_second_status_any_flag,
	output logic o_irq
);
	import lcs_pkg::*;

	lcs_state_s s_q;
	lcs_state_s s_d;
	lcs_cmp_if cmp_bus();

	logic acc;
	logic addr_ok;
	logic rd;
	logic st_read;
	logic [IDX_W-1:0] idx;
	logic [7:0] lim_k;
	logic [7:0] wr_k;
	logic [7:0] rd_byte;
	logic [7:0] event_v;
	logic [7:0] clr_ok;
	logic hot;
	logic cool;
	logic signed [8:0] release_lvl;

	// limit comparators
	lcs_compare u_compare (
		.cmp(cmp_bus)
	);

	// measured values into the comparator bus
	assign cmp_bus.meas = {i_temp_level, i_rail_level};
	assign cmp_bus.tach = i_tach_count;

	// unpack the limit array into low/high pairs per channel
	for (genvar c = 0; c < NUM_CHAN; c++) begin : g_lim
		assign cmp_bus.lim_low[c] = s_q.limit[2*c];
		assign cmp_bus.lim_high[c] = s_q.limit[2*c+1];
	end

	// each fan limit is high byte over low byte; fan four rides pwm three
	for (genvar f = 0; f < NUM_FAN; f++) begin : g_fan
		assign cmp_bus.fan_min[f] = {s_q.limit[TACH_BASE+2*f+1],
			s_q.limit[TACH_BASE+2*f]};
		if (f < NUM_PWM) begin : g_own
			assign cmp_bus.fan_run[f] = i_pwm_on[f];
		end else begin : g_shared
			assign cmp_bus.fan_run[f] = i_pwm_on[COOLER_FOUR_PWM];
		end
	end

	// overheat trips above the threshold and releases more than four degrees below
	always_comb begin
		hot = 1'b0;
		cool = 1'b1;
		release_lvl = $signed({i_critical_temp_threshold[7],
			i_critical_temp_threshold}) - OVERHEAT_HYST;
		for (int t = 0; t < NUM_TEMP; t++) begin
			if ($signed(i_temp_level[t]) >
				$signed(i_critical_temp_threshold)) begin
				hot = 1'b1;
			end
			if ($signed({i_temp_level[t][7], i_temp_level[t]}) >=
				release_lvl) begin
				cool = 1'b0;
			end
		end
	end

	// raw fault events feeding the sticky status bits
	always_comb begin
		event_v = '0;
		event_v[ST_RAIL_12V] = cmp_bus.chan_fault[RAIL_12V_CHAN];
		event_v[ST_OVERHEAT] = hot;
		event_v[ST_COOLER_FIRST +: NUM_FAN] = cmp_bus.fan_fault;
		event_v[ST_DIODE_FIRST +: NUM_DIODE] = i_diode_fault;
	end

	// a read may drop a bit only once its cause is gone
	always_comb begin
		clr_ok = ~event_v;
		clr_ok[ST_OVERHEAT] = cool & ~hot;
	end

	// address phase decode; only aligned word transfers are accepted
	assign acc = i_hsel & i_hready & i_htrans[1];
	assign idx = i_haddr[IDX_MSB:WORD_SHIFT];
	assign addr_ok = (i_haddr[31:IDX_MSB+1] == '0) &&
		(i_haddr[WORD_SHIFT-1:0] == '0) && (i_hsize == HSIZE_WORD);
	assign rd = acc & ~i_hwrite & addr_ok;
	assign st_read = rd && (idx == FAULT_STATUS_TWO_IDX);
	assign lim_k = idx - RAIL_2V5_LOW_LIMIT_IDX;
	assign wr_k = s_q.wr_idx - RAIL_2V5_LOW_LIMIT_IDX;

	// read multiplexer; unmapped words and reserved bits read zero
	always_comb begin
		rd_byte = '0;
		if (idx == FAULT_STATUS_TWO_IDX) begin
			rd_byte = s_q.status;
		end else if (idx == CORE_VOLTAGE_CODE_IDX) begin
			// live pins, so valid right after power-up
			rd_byte = {{(8-VID_W){1'b0}}, i_core_voltage_code_bits};
		end else if (idx >= RAIL_2V5_LOW_LIMIT_IDX &&
			idx <= FAN_FOUR_MIN_COUNT_HIGH_IDX) begin
			rd_byte = s_q.limit[lim_k[LIMIT_IDX_W-1:0]];
		end
	end

	// next state: writes, read data, sticky status, reset
	always_comb begin
		s_d = s_q;
		// write data arrives one phase after its address
		if (s_q.wr_pend && i_hready) begin
			if (s_q.wr_idx >= RAIL_2V5_LOW_LIMIT_IDX &&
				s_q.wr_idx <= FAN_FOUR_MIN_COUNT_HIGH_IDX) begin
				// no lock input exists, so limits always take writes
				s_d.limit[wr_k[LIMIT_IDX_W-1:0]] =
					i_hwdata[7:0];
			end
		end
		if (i_hready) begin
			s_d.wr_pend = acc & i_hwrite & addr_ok;
			s_d.wr_idx = idx;
			s_d.rdata = rd ? {24'h000000, rd_byte} : '0;
		end
		// set wins over a read clear in the same cycle
		s_d.status = event_v |
			(s_q.status & ~({8{st_read}} & clr_ok));
		if (i_reset) begin
			for (int k = 0; k < NUM_LIMITS; k++) begin
				s_d.limit[k] = lcs_limit_reset(k);
			end
			s_d.status = STATUS_RESET;
			s_d.wr_pend = 1'b0;
			s_d.wr_idx = '0;
			s_d.rdata = '0;
		end
	end

	// state register; the enable freezes everything except reset
	always_ff @(posedge i_clk) begin
		if (i_reset || i_clk_en) begin
			s_q <= s_d;
		end
	end

	// while frozen the bus is stalled, so no phase is lost
	assign o_hreadyout = i_clk_en;
	assign o_hresp = HRESP_OKAY;
	assign o_hrdata = s_q.rdata;

	// summary and interrupt levels
	assign o_limit_fault = cmp_bus.chan_fault;
	assign o_second_status_any_flag = |s_q.status;
	assign o_irq = |s_q.status;

endmodule
`default_nettype wire

// File: tb/lcs_monitor.sv
// port checker for status latching and register reads
`timescale 1ns/1ps
`default_nettype none
module lcs_monitor (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_clk_en,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic i_hready,
	input wire logic [31:0] o_hrdata,
	input wire logic [lcs_pkg::NUM_TEMP-1:0][7:0] i_temp_level,
	input wire logic [7:0] i_critical_temp_threshold,
	input wire logic [lcs_pkg::NUM_DIODE-1:0] i_diode_fault,
	input wire logic [lcs_pkg::VID_W-1:0] i_core_voltage_code_bits,
	input wire logic [lcs_pkg::NUM_CHAN-1:0] o_limit_fault,
	input wire logic o_second_status_any_flag,
	input wire logic o_irq
);
	import lcs_pkg::*;
	logic acc, rd_st, rd_id, hot;
	logic signed [7:0] thr;
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);
	// accepted reads decoded as the slave takes them
	// non-word sizes are refused by the slave, so they are no reads here
	assign acc = i_hsel && i_hready && i_htrans[1] && i_clk_en &&
		i_hsize == HSIZE_WORD;
	assign rd_st = acc && !i_hwrite && i_haddr == 32'h00000108;
	assign rd_id = acc && !i_hwrite && i_haddr == 32'h0000010c;
	assign thr = i_critical_temp_threshold;
	// any temperature past the overheat threshold, signed compare
	always_comb begin
		hot = 1'b0;
		for (int k = 0; k < NUM_TEMP; k++) begin
			hot = hot | ($signed(i_temp_level[k]) > thr);
		end
	end
	rail_sets_a: assert property (i_clk_en && o_limit_fault[4] |=> o_irq)
		else $error("rail fault not latched");
	hot_sets_a: assert property (i_clk_en && hot |=> o_irq)
		else $error("overheat not latched");
	diode_sets_a: assert property (i_clk_en && |i_diode_fault |=> o_irq)
		else $error("diode fault not latched");
	flag_or_a: assert property (o_second_status_any_flag == o_irq)
		else $error("summary flag differs from status");
	irq_holds_a: assert property (o_irq && !rd_st |=> o_irq)
		else $error("request dropped without read");
	// a drop right after reset is the reset's doing, not a read's
	irq_drop_a: assert property ($fell(o_irq) && !$past(i_reset) |->
		$past(rd_st)) else $error("request fell without read");
	st_read_a: assert property (rd_st |=>
		(o_hrdata[7:0] != 8'h00) == $past(o_irq) && o_hrdata[31:8] == 24'h0)
		else $error("status read mismatch");
	id_read_a: assert property (rd_id |=>
		o_hrdata == {27'h0, $past(i_core_voltage_code_bits)})
		else $error("id read mismatch");
	cover property (rd_st && o_irq);
	cover property (hot);
	cover property ($fell(o_irq));
endmodule
bind lcs_top lcs_monitor lcs_monitor_inst (.i_clk, .i_reset, .i_clk_en,
	.i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize, .i_hready, .o_hrdata,
	.i_temp_level, .i_critical_temp_threshold, .i_diode_fault,
	.i_core_voltage_code_bits, .o_limit_fault, .o_second_status_any_flag,
	.o_irq);
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the limit compare register block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import lcs_pkg::*;
	logic clk, rst, en, hsel, hwrite, ready, any_f, irq;
	logic [31:0] haddr, hwdata, rdata, rd;
	logic [1:0] htrans, resp, diode;
	logic [2:0] hsize, pwm;
	logic [NUM_VOLT-1:0][7:0] rail;
	logic [NUM_TEMP-1:0][7:0] temp;
	logic [NUM_FAN-1:0][15:0] tach;
	logic [7:0] thr, lim_f, e;
	logic [4:0] vid;
	int fails, tests_run;
	lcs_top lcs_top_inst (.i_clk(clk), .i_reset(rst), .i_clk_en(en),
		.i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite),
		.i_hsize(hsize), .i_hwdata(hwdata), .i_hready(ready),
		.o_hreadyout(ready), .o_hresp(resp), .o_hrdata(rdata),
		.i_rail_level(rail), .i_temp_level(temp), .i_tach_count(tach),
		.i_pwm_on(pwm), .i_critical_temp_threshold(thr),
		.i_diode_fault(diode), .i_core_voltage_code_bits(vid),
		.o_limit_fault(lim_f), .o_second_status_any_flag(any_f), .o_irq(irq));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// one single word transfer, address phase held until ready
	task automatic xfer(input logic w, input logic [7:0] ix,
		input logic [31:0] wd, output logic [31:0] q);
		@(posedge clk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {22'h0, ix, 2'h0};
		do @(posedge clk); while (ready !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk); while (ready !== 1'b1);
		q = rdata;
	endtask
	task automatic chk(input string nm, input logic [31:0] ex, got);
		tests_run++;
		if (got !== ex) begin
			fails++;
			$display("FAIL %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic rc(input logic [7:0] ix, input logic [31:0] ex);
		xfer(1'b0, ix, 32'h0, rd);
		chk($sformatf("reg %h", ix), ex, rd);
		chk("hresp", 32'h0, {30'h0, resp});
	endtask
	task automatic wr(input logic [7:0] ix, input logic [7:0] v);
		xfer(1'b1, ix, {24'h0, v}, rd);
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// power-on limit values: rails, then temperatures, then fan bytes
	function automatic logic [7:0] dflt(input int k);
		if (k >= 16) return 8'hff;
		if (k >= 10) return (k % 2) ? 8'h7f : 8'h81;
		return (k % 2) ? 8'hff : 8'h00;
	endfunction
	// about 140 transfers fit well inside this span
	initial begin
		repeat (20000) @(posedge clk);
		fails++;
		conclude();
	end
	initial begin
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = HSIZE_WORD;
		en = 1'b1;
		rst = 1'b1;
		rail = {5{8'h80}};
		temp = {3{8'h19}};
		tach = {4{16'h1000}};
		pwm = 3'h7;
		thr = 8'h50;
		diode = 2'h0;
		vid = 5'h15;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rc(8'h42, 32'h0);
		rc(8'h43, 32'h15);
		for (int k = 0; k < 24; k++) rc(8'h44 + 8'(k), dflt(k));
		$display("test reset values done");
		for (int k = 0; k < 24; k++) wr(8'h44 + 8'(k), 8'ha5 ^ 8'(k));
		for (int k = 0; k < 24; k++) rc(8'h44 + 8'(k), 8'ha5 ^ 8'(k));
		wr(8'h43, 8'hff);
		rc(8'h43, 32'h15);
		rc(8'h60, 32'h0);
		// byte-size transfers are refused: read zero, write dropped
		hsize <= 3'h0;
		wr(8'h44, 8'h11);
		rc(8'h43, 32'h0);
		hsize <= HSIZE_WORD;
		rc(8'h44, 32'ha5);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rc(8'h4d, 32'hff);
		$display("test access done");
		wr(8'h4d, 8'h90);
		wr(8'h4c, 8'h40);
		rail[4] <= 8'h90;
		rc(8'h42, 32'h0);
		rail[4] <= 8'h91;
		rc(8'h42, 32'h1);
		chk("channel faults", 32'h10, {24'h0, lim_f});
		rc(8'h42, 32'h1);
		rail[4] <= 8'h41;
		rc(8'h42, 32'h1);
		rc(8'h42, 32'h0);
		rail[4] <= 8'h40;
		rc(8'h42, 32'h1);
		chk("channel faults", 32'h10, {24'h0, lim_f});
		rail[4] <= 8'h80;
		rc(8'h42, 32'h1);
		rc(8'h42, 32'h0);
		$display("test rail limits done");
		temp[1] <= 8'h51;
		rc(8'h42, 32'h2);
		temp[1] <= 8'h4c;
		rc(8'h42, 32'h2);
		rc(8'h42, 32'h2);
		temp[1] <= 8'h4b;
		rc(8'h42, 32'h2);
		rc(8'h42, 32'h0);
		wr(8'h51, 8'h20);
		temp[1] <= 8'h20;
		rc(8'h51, 32'h20);
		chk("channel faults", 32'h0, {24'h0, lim_f});
		temp[1] <= 8'h21;
		rc(8'h51, 32'h20);
		chk("channel faults", 32'h40, {24'h0, lim_f});
		wr(8'h50, 8'he0);
		temp[1] <= 8'he0;
		rc(8'h50, 32'he0);
		chk("channel faults", 32'h40, {24'h0, lim_f});
		temp[1] <= 8'h19;
		$display("test temperatures done");
		for (int f = 0; f < 4; f++) begin
			e = 8'h04 << f;
			wr(8'h54 + 8'(2 * f), 8'h34);
			wr(8'h55 + 8'(2 * f), 8'h12);
			tach[f] <= 16'h1234;
			rc(8'h42, 32'h0);
			tach[f] <= 16'h1235;
			pwm <= (f == 3) ? 3'h3 : ~(3'h1 << f);
			rc(8'h42, 32'h0);
			pwm <= 3'h7;
			rc(8'h42, {24'h0, e});
			tach[f] <= 16'h1000;
			rc(8'h42, {24'h0, e});
			rc(8'h42, 32'h0);
		end
		wr(8'h54, 8'h00);
		wr(8'h55, 8'h00);
		tach[0] <= 16'h8000;
		rc(8'h42, 32'h0);
		$display("test fans done");
		for (int d = 0; d < 2; d++) begin
			diode <= 2'h1 << d;
			rc(8'h42, {24'h0, 8'h40 << d});
			chk("summary flag", 32'h1, {31'h0, any_f});
			chk("irq", 32'h1, {31'h0, irq});
			diode <= 2'h0;
			rc(8'h42, {24'h0, 8'h40 << d});
			rc(8'h42, 32'h0);
		end
		$display("test diodes done");
		// enable low: bus stalls and a fault must not latch yet
		en <= 1'b0;
		diode <= 2'h1;
		repeat (3) @(posedge clk);
		chk("hreadyout", 32'h0, {31'h0, ready});
		chk("irq frozen", 32'h0, {31'h0, irq});
		en <= 1'b1;
		rc(8'h42, 32'h40);
		diode <= 2'h0;
		rc(8'h42, 32'h40);
		rc(8'h42, 32'h0);
		$display("test clock enable done");
		conclude();
	end
endmodule
`default_nettype wire
